// >>> hw/io_port_pkg.sv
// Overview of operation
// - eight-pin port, address out or counter in
// - direction bit 1 output, 0 input; reset 0
// - direction write-only, shares address with pin levels
// - reading shared address returns live pin levels
// - lpc off only when all four enables clear
// - port e function from lpc state and direction
// - pe7: gpio by direction, else serirq two-way
// - pe6: gpio by direction, else lclk input
// - pe5: gpio by direction, else lreset input
package io_port_pkg;
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 8;
    localparam int          PA_W         = 8;
    localparam int          PE_W         = 3;

    // register offsets
    localparam logic [3:0]  OFS_PA_DIR   = 4'h0;  // write: direction, read: pin levels
    localparam logic [3:0]  OFS_PA_ODR   = 4'h1;
    localparam logic [3:0]  OFS_PE_DIR   = 4'h2;  // write: direction, read: pin levels
    localparam logic [3:0]  OFS_PE_ODR   = 4'h3;
    localparam logic [3:0]  OFS_HIC0     = 4'h4;
    localparam logic [3:0]  OFS_HIC5     = 4'h5;

    // field positions
    localparam int          PE_LO        = 5;     // port e pins 7..5 sit in bits 7..5
    localparam int          PE_HI        = 7;
    localparam int          PE_SERIRQ    = 2;     // index inside the 3-bit port e field
    localparam int          PE_LCLK      = 1;
    localparam int          PE_LRESET    = 0;
    localparam int          LPC_CH1_BIT  = 7;     // control0: channel enables
    localparam int          LPC_CH2_BIT  = 6;
    localparam int          LPC_CH3_BIT  = 5;
    localparam int          SERIRQ_EN_BIT = 0;    // control5: serial irq enable

    // reset values
    localparam logic [7:0]  RST_DIR      = 8'h00;
    localparam logic [7:0]  RST_ODR      = 8'h00;
    localparam logic [7:0]  RST_HIC      = 8'h00;
    localparam logic [7:0]  RD_ZERO      = 8'h00;
    localparam logic [2:0]  PE_ZERO      = 3'h0;

    typedef struct packed {
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic drive;
        logic oe;
    } serirq_drv_t;

    typedef struct packed {
        logic serirq;
        logic lclk;
        logic lreset_n;
    } lpc_pins_t;
endpackage : io_port_pkg

// >>> hw/port_e_mux.sv
`timescale 1ns/10ps
// pin function selection for port e pins 7..5
module port_e_mux
    import io_port_pkg::*;
(
    input  wire logic            lpc_en_in,
    input  wire logic [PE_W-1:0] dir_in,
    input  wire logic [PE_W-1:0] odr_in,
    input  wire logic [PE_W-1:0] lvl_in,
    input  wire serirq_drv_t     serirq_in,
    output logic      [PE_W-1:0] next_pe_out_out,
    output logic      [PE_W-1:0] next_pe_oe_n_out,
    output lpc_pins_t            next_lpc_out
);
    logic [PE_W-1:0] lpc_oe;
    logic [PE_W-1:0] lpc_dat;

    // with lpc on only serirq may drive; lclk and lreset stay inputs
    assign lpc_oe  = {serirq_in.oe, 1'b0, 1'b0};
    assign lpc_dat = {serirq_in.drive, 1'b0, 1'b0};

    // direction bits are ignored while lpc owns the pins
    assign next_pe_oe_n_out = lpc_en_in ? ~lpc_oe : ~dir_in;
    assign next_pe_out_out  = lpc_en_in ? lpc_dat : (odr_in & dir_in);

    // idle values toward the host core keep it quiet when lpc is off
    assign next_lpc_out.serirq   = lpc_en_in ? lvl_in[PE_SERIRQ] : 1'b1;
    assign next_lpc_out.lclk     = lpc_en_in & lvl_in[PE_LCLK];
    assign next_lpc_out.lreset_n = lpc_en_in ? lvl_in[PE_LRESET] : 1'b1;
endmodule : port_e_mux

// >>> hw/io_port_top.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
// port a gpio with shared direction/level address, plus port e lpc pin sharing
module io_port_top
    import io_port_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              we_in,
    input  wire logic              re_in,
    output logic      [DATA_W-1:0] rdata_out,
    // port a pins
    input  wire logic [PA_W-1:0]   pa_pin_in,
    output logic      [PA_W-1:0]   pa_pin_out,
    output logic      [PA_W-1:0]   pa_pin_oe_n_out,
    // port a alternate functions
    input  wire logic [PA_W-1:0]   addr_sel_in,
    input  wire logic [PA_W-1:0]   addr_bits_in,
    output logic      [PA_W-1:0]   event_count_out,
    // port e pins 7..5
    input  wire logic [PE_W-1:0]   pe_pin_in,
    output logic      [PE_W-1:0]   pe_pin_out,
    output logic      [PE_W-1:0]   pe_pin_oe_n_out,
    // lpc core side
    input  wire logic              serirq_drive_in,
    input  wire logic              serirq_oe_in,
    output logic                   serirq_level_out,
    output logic                   lclk_out,
    output logic                   lreset_n_out,
    output logic                   lpc_enable_out
);
    logic              rst_sync1;
    logic              rst_n;
    logic [PA_W-1:0]   pa_sync1;
    logic [PA_W-1:0]   pa_lvl;
    logic [PE_W-1:0]   pe_sync1;
    logic [PE_W-1:0]   pe_lvl;
    logic [PA_W-1:0]   port_a_direction;
    logic [PA_W-1:0]   port_a_output_data;
    logic [PE_W-1:0]   port_e_direction;
    logic [PE_W-1:0]   port_e_output_data;
    logic [DATA_W-1:0] host_if_control0;
    logic [DATA_W-1:0] host_if_control5;
    reg_req_t          req;
    serirq_drv_t       serirq_drv;
    lpc_pins_t         next_lpc;
    lpc_pins_t         lpc_q;
    logic [PE_W-1:0]   next_pe_out;
    logic [PE_W-1:0]   next_pe_oe_n;
    logic [PA_W-1:0]   next_pa_out;
    logic [PA_W-1:0]   next_pa_oe_n;
    logic [DATA_W-1:0] next_rdata;
    logic              lpc_en;

    function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    // pins are asynchronous to clk_in, so two flops before anything reads them
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pa_sync1 <= RST_DIR;
            pa_lvl   <= RST_DIR;
            pe_sync1 <= PE_ZERO;
            pe_lvl   <= PE_ZERO;
        end else begin
            pa_sync1 <= pa_pin_in;
            pa_lvl   <= pa_sync1;
            pe_sync1 <= pe_pin_in;
            pe_lvl   <= pe_sync1;
        end
    end

    assign req = '{we: we_in, re: re_in, addr: addr_in, wdata: wdata_in};

    // register writes; direction only reachable by write
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            port_a_direction   <= RST_DIR;
            port_a_output_data <= RST_ODR;
            port_e_direction   <= PE_ZERO;
            port_e_output_data <= PE_ZERO;
            host_if_control0   <= RST_HIC;
            host_if_control5   <= RST_HIC;
        end else if (req.we) begin
            if (hit(req, OFS_PA_DIR)) begin
                port_a_direction <= req.wdata;
            end else if (hit(req, OFS_PA_ODR)) begin
                port_a_output_data <= req.wdata;
            end else if (hit(req, OFS_PE_DIR)) begin
                port_e_direction <= req.wdata[PE_HI:PE_LO];
            end else if (hit(req, OFS_PE_ODR)) begin
                port_e_output_data <= req.wdata[PE_HI:PE_LO];
            end else if (hit(req, OFS_HIC0)) begin
                host_if_control0 <= req.wdata;
            end else if (hit(req, OFS_HIC5)) begin
                host_if_control5 <= req.wdata;
            end
        end
    end

    // read decode; shared addresses return pin levels, never the direction bits
    assign next_rdata =
        !req.re                  ? RD_ZERO :
        hit(req, OFS_PA_DIR)     ? pa_lvl :
        hit(req, OFS_PA_ODR)     ? port_a_output_data :
        hit(req, OFS_PE_DIR)     ? {pe_lvl, {PE_LO{1'b0}}} :
        hit(req, OFS_PE_ODR)     ? {port_e_output_data, {PE_LO{1'b0}}} :
        hit(req, OFS_HIC0)       ? host_if_control0 :
        hit(req, OFS_HIC5)       ? host_if_control5 : RD_ZERO;

    // any one enable keeps the lpc interface alive
    assign lpc_en = host_if_control0[LPC_CH1_BIT] | host_if_control0[LPC_CH2_BIT]
                  | host_if_control0[LPC_CH3_BIT] | host_if_control5[SERIRQ_EN_BIT];

    // address select wins over gpio; a selected pin drives even if direction is input
    assign next_pa_oe_n = ~(port_a_direction | addr_sel_in);
    assign next_pa_out  = (addr_sel_in & addr_bits_in)
                        | (~addr_sel_in & port_a_direction & port_a_output_data);

    assign serirq_drv = '{drive: serirq_drive_in, oe: serirq_oe_in};

    port_e_mux u_pe_mux (
        .lpc_en_in        (lpc_en),
        .dir_in           (port_e_direction),
        .odr_in           (port_e_output_data),
        .lvl_in           (pe_lvl),
        .serirq_in        (serirq_drv),
        .next_pe_out_out  (next_pe_out),
        .next_pe_oe_n_out (next_pe_oe_n),
        .next_lpc_out     (next_lpc)
    );

    // pin and data outputs registered; one cycle of latency for clean edges
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out       <= RD_ZERO;
            pa_pin_out      <= RST_ODR;
            pa_pin_oe_n_out <= ~RST_DIR;
            pe_pin_out      <= PE_ZERO;
            pe_pin_oe_n_out <= ~PE_ZERO;
            lpc_q           <= '{serirq: 1'b1, lclk: 1'b0, lreset_n: 1'b1};
            lpc_enable_out  <= 1'b0;
        end else begin
            rdata_out       <= next_rdata;
            pa_pin_out      <= next_pa_out;
            pa_pin_oe_n_out <= next_pa_oe_n;
            pe_pin_out      <= next_pe_out;
            pe_pin_oe_n_out <= next_pe_oe_n;
            lpc_q           <= next_lpc;
            lpc_enable_out  <= lpc_en;
        end
    end

    // counter inputs see the synchronised level of every pin
    assign event_count_out  = pa_lvl;
    assign serirq_level_out = lpc_q.serirq;
    assign lclk_out         = lpc_q.lclk;
    assign lreset_n_out     = lpc_q.lreset_n;

    property p_dir_reset;
        @(posedge clk_in) $rose(rst_n) |-> (port_a_direction == RST_DIR && &pa_pin_oe_n_out);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");

    property p_dir_write;
        @(posedge clk_in) disable iff (!rst_n)
        (we_in && addr_in == OFS_PA_DIR) |=> port_a_direction == $past(wdata_in);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_read_levels;
        @(posedge clk_in) disable iff (!rst_n)
        (re_in && addr_in == OFS_PA_DIR) |=> rdata_out == $past(pa_lvl);
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("shared read not pin levels");

    property p_pa_oe;
        @(posedge clk_in) disable iff (!rst_n)
        ##1 pa_pin_oe_n_out == ~($past(port_a_direction) | $past(addr_sel_in));
    endproperty
    a_pa_oe: assert property (p_pa_oe) else $error("port a enable mismatch");

    property p_pa_data;
        @(posedge clk_in) disable iff (!rst_n)
        ##1 ((pa_pin_out ^ $past(port_a_output_data))
             & $past(port_a_direction) & ~$past(addr_sel_in)) == RD_ZERO;
    endproperty
    a_pa_data: assert property (p_pa_data) else $error("output pin data wrong");

    property p_pa_addr;
        @(posedge clk_in) disable iff (!rst_n)
        ##1 (((pa_pin_out ^ $past(addr_bits_in)) | ~pa_pin_oe_n_out ^ 8'hff)
             & $past(addr_sel_in)) == RD_ZERO;
    endproperty
    a_pa_addr: assert property (p_pa_addr) else $error("address output wrong");

    property p_lpc_off;
        @(posedge clk_in) disable iff (!rst_n)
        (host_if_control0[LPC_CH1_BIT:LPC_CH3_BIT] == 3'h0 && !host_if_control5[SERIRQ_EN_BIT])
        |=> !lpc_enable_out;
    endproperty
    a_lpc_off: assert property (p_lpc_off) else $error("lpc enabled with all clear");

    property p_pe_gpio;
        @(posedge clk_in) disable iff (!rst_n)
        !lpc_en |=> pe_pin_oe_n_out == ~$past(port_e_direction) && lreset_n_out && !lclk_out;
    endproperty
    a_pe_gpio: assert property (p_pe_gpio) else $error("port e gpio mode wrong");

    property p_serirq;
        @(posedge clk_in) disable iff (!rst_n)
        lpc_en |=> pe_pin_oe_n_out[PE_SERIRQ] == ~$past(serirq_oe_in)
                   && pe_pin_out[PE_SERIRQ] == $past(serirq_drive_in);
    endproperty
    a_serirq: assert property (p_serirq) else $error("serirq pin not driven by lpc");

    property p_lclk_in;
        @(posedge clk_in) disable iff (!rst_n)
        lpc_en |=> pe_pin_oe_n_out[PE_LCLK] && lclk_out == $past(pe_lvl[PE_LCLK]);
    endproperty
    a_lclk_in: assert property (p_lclk_in) else $error("lclk pin not an input");

    property p_lreset_in;
        @(posedge clk_in) disable iff (!rst_n)
        lpc_en |=> pe_pin_oe_n_out[PE_LRESET] && lreset_n_out == $past(pe_lvl[PE_LRESET]);
    endproperty
    a_lreset_in: assert property (p_lreset_in) else $error("lreset pin not an input");
endmodule : io_port_top

// >>> bench/pin_partner.sv
`timescale 1ns/10ps
// outside world at the pads: the device wins where its enable is low
module pin_partner
    import io_port_pkg::*;
(
    input  wire logic [PA_W-1:0] pa_out_in,
    input  wire logic [PA_W-1:0] pa_oe_n_in,
    input  wire logic [PA_W-1:0] pa_ext_in,
    output logic      [PA_W-1:0] pa_lvl_out,
    input  wire logic [PE_W-1:0] pe_out_in,
    input  wire logic [PE_W-1:0] pe_oe_n_in,
    input  wire logic [PE_W-1:0] pe_ext_in,
    output logic      [PE_W-1:0] pe_lvl_out
);
    // external drivers step back on driven pins, so no contention is modelled
    assign pa_lvl_out = (~pa_oe_n_in & pa_out_in) | (pa_oe_n_in & pa_ext_in);
    assign pe_lvl_out = (~pe_oe_n_in & pe_out_in) | (pe_oe_n_in & pe_ext_in);
endmodule : pin_partner

// >>> bench/tb_io_port_direction_and_lpc_pinmux.sv
`timescale 1ns/10ps
module tb_io_port_direction_and_lpc_pinmux
    import io_port_pkg::*;
;
    logic              clk_in, arst_n_in, we, re, sdrv, soe, slvl, lclk, lrst_n, lpc_en, en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata, rdata, pa_in, pa_out, pa_oe_n, sel, bits, evc, pa_ext;
    logic [7:0]        d, dir, odr, ext, s, h0, h5, lv;
    logic [PE_W-1:0]   pe_in, pe_out, pe_oe_n, pe_ext, eo, en_oe;
    logic [31:0]       seed = 32'h49;
    int                n_errors = 0, compares = 0, cycles = 0, i, m;

    io_port_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
        .we_in(we), .re_in(re), .rdata_out(rdata), .pa_pin_in(pa_in), .pa_pin_out(pa_out),
        .pa_pin_oe_n_out(pa_oe_n), .addr_sel_in(sel), .addr_bits_in(bits),
        .event_count_out(evc), .pe_pin_in(pe_in), .pe_pin_out(pe_out),
        .pe_pin_oe_n_out(pe_oe_n), .serirq_drive_in(sdrv), .serirq_oe_in(soe),
        .serirq_level_out(slvl), .lclk_out(lclk), .lreset_n_out(lrst_n),
        .lpc_enable_out(lpc_en));
    pin_partner pads (.pa_out_in(pa_out), .pa_oe_n_in(pa_oe_n), .pa_ext_in(pa_ext),
        .pa_lvl_out(pa_in), .pe_out_in(pe_out), .pe_oe_n_in(pe_oe_n), .pe_ext_in(pe_ext),
        .pe_lvl_out(pe_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // xorshift keeps the run repeatable
    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    // level seen at a pad given the device drive and the outside value
    function logic [7:0] lvl(input logic [7:0] oe_n, input logic [7:0] o, input logic [7:0] x);
        return (~oe_n & o) | (oe_n & x);
    endfunction : lvl

    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr  <= a;
        wdata <= v;
        we    <= 1'b1;
        @(posedge clk_in);
        we    <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk_in);
        re   <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // two sync flops plus registered outputs need a few edges
    task settle();
        repeat (6) @(posedge clk_in);
        #1;
    endtask : settle

    task final_report();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // hang guard, the tests need about 750 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        arst_n_in = 1'b0;
        {we, re, sdrv, soe} = 4'h0;
        addr = 4'h0;
        {wdata, sel, bits} = 24'h0;
        pa_ext = 8'h5a;
        pe_ext = 3'h5;
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        settle();
        check(pa_oe_n, 8'hff);
        check(pe_oe_n, 3'h7);
        check({lpc_en, lclk, lrst_n, slvl}, 8'h3);
        rd(OFS_PA_DIR, d);
        check(d, 8'h5a);
        $display("test reset done");
        for (i = 0; i < 40; i++) begin
            dir = (i == 0) ? 8'hff : rnd();
            odr = rnd();
            ext = rnd();
            s = (i < 20) ? 8'h00 : rnd();
            wr(OFS_PA_ODR, odr);
            wr(OFS_PA_DIR, dir);
            @(posedge clk_in);
            pa_ext <= ext;
            sel    <= s;
            bits   <= rnd();
            settle();
            lv = lvl(~(dir | s), (s & bits) | (~s & dir & odr), ext);
            check(pa_oe_n, ~(dir | s));
            check(pa_out, (s & bits) | (~s & dir & odr));
            check(evc, lv);
            rd(OFS_PA_DIR, d);
            check(d, lv);
            rd(OFS_PA_ODR, d);
            check(d, odr);
        end
        $display("test port_a done");
        for (m = 0; m < 5; m++) begin
            h0 = (m == 0) ? 8'h1f : (m == 4) ? 8'h00 : 8'h80 >> (m - 1);
            h5 = (m == 0) ? 8'hfe : (m == 4) ? 8'h01 : 8'h00;
            en = (m != 0);
            dir = en ? 8'he0 : rnd();
            odr = rnd();
            wr(OFS_HIC0, h0);
            wr(OFS_HIC5, h5);
            wr(OFS_PE_ODR, odr);
            wr(OFS_PE_DIR, dir);
            @(posedge clk_in);
            pe_ext <= PE_W'(rnd());
            sdrv   <= 1'(rnd());
            soe    <= (m == 2) ? 1'b0 : 1'b1;
            settle();
            check(lpc_en, en);
            en_oe = en ? {~soe, 2'b11} : ~dir[7:5];
            eo = en ? {sdrv, 2'b00} : dir[7:5] & odr[7:5];
            lv = lvl(en_oe, eo, pe_ext);
            check(pe_oe_n, en_oe);
            if (en) begin
                if (soe) begin
                    check(pe_out[2], sdrv);
                end
                check({slvl, lclk, lrst_n}, lv[2:0]);
                check(pe_oe_n[0], 1'b1);
            end else begin
                check(pe_out, eo);
                check({lclk, lrst_n, slvl}, 8'h3);
                rd(OFS_PE_DIR, d);
                check(d, {lv[2:0], 5'h00});
            end
            rd(OFS_HIC0, d);
            check(d, h0);
            rd(OFS_HIC5, d);
            check(d, h5);
            rd(OFS_PE_ODR, d);
            check(d, {odr[7:5], 5'h00});
        end
        $display("test port_e done");
        wr(4'hf, 8'hff);
        rd(4'hf, d);
        check(d, 8'h00);
        check(lpc_en, 1'b1);
        $display("test unmapped done");
        final_report();
    end
endmodule : tb_io_port_direction_and_lpc_pinmux
